// [hdl/osbb_host.sv]
// processor end: bus cycle sequencer, decode, clock, reset and power-fail
// assumes: card end on the same clock; slot lines pass a 2-flop sync
`timescale 1ns/10ps
module osbb_host #(
  parameter int PFAIL_RISE = osbb_pkg::PFAIL_RISE_CYC,
  parameter int FRAME_LEN  = osbb_pkg::FRAME_CYC
) (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // cycle request
  input  wire logic        REQ_I,
  input  wire logic        REQ_WRITE_I,
  input  wire logic        REQ_IO_I,
  input  wire logic [19:0] REQ_ADDR_I,
  input  wire logic [7:0]  REQ_DATA_I,
  output logic             BUSY_O,
  output logic             DONE_O,
  output logic [7:0]       RD_DATA_O,
  // board status
  input  wire logic        SUPPLY_OK_I,
  input  wire logic        HOLD_I,
  input  wire logic        MEM_256K_I,
  output logic             SYS_IRQ_O,
  output logic             COMM_IRQ_O,
  // backplane
  osbb_if.host             bus
);

  // ********************************
  // bus clock divider
  // ********************************
  logic [3:0] div_cnt, next_div_cnt;
  logic       clk8, next_clk8;
  logic       fall_en;
  always_comb begin
    next_div_cnt = div_cnt + 4'h1;
    next_clk8    = clk8;
    fall_en      = 1'b0;
    if (div_cnt == 4'(osbb_pkg::BUS_HALF_CYC - 1)) begin
      next_div_cnt = 4'h0;
      next_clk8    = ~clk8;
      fall_en      = clk8;
    end
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      div_cnt <= 4'h0;
      clk8    <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      clk8    <= next_clk8;
    end
  end
  assign bus.bus_clock_8m = clk8;

  // ********************************
  // input synchronisers
  // ********************************
  // reset to idle levels, so no false hold or size after reset
  logic [5:0] s1, s2;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s1 <= 6'h3a;
      s2 <= 6'h3a;
    end else begin
      s1 <= {bus.slot_wait_n, bus.system_irq_n, bus.comm_shared_irq_n,
             HOLD_I, SUPPLY_OK_I, MEM_256K_I};
      s2 <= s1;
    end
  end
  logic wait_s, sirq_s, cirq_s, hold_s, sup_s, msize_s;
  assign {wait_s, sirq_s, cirq_s, hold_s, sup_s, msize_s} = s2;

  // ********************************
  // power-fail and reset
  // ********************************
  logic [23:0] pf_cnt, next_pf_cnt;
  logic        pfail_n, next_pfail_n;
  always_comb begin
    next_pf_cnt  = pf_cnt;
    next_pfail_n = pfail_n;
    if (!sup_s) begin
      next_pf_cnt  = 24'h0; // falls at once on supply loss
      next_pfail_n = 1'b0;
    end else if (pf_cnt != 24'(PFAIL_RISE)) begin
      next_pf_cnt = pf_cnt + 24'h1;
    end else begin
      next_pfail_n = 1'b1;
    end
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pf_cnt  <= 24'h0;
      pfail_n <= 1'b0;
    end else begin
      pf_cnt  <= next_pf_cnt;
      pfail_n <= next_pfail_n;
    end
  end
  assign bus.power_fail_n = pfail_n;
  assign bus.bus_reset_n  = pfail_n;

  // ********************************
  // bus cycle sequencer
  // ********************************
  osbb_pkg::osbb_state_e st, next_st;
  logic [19:0] addr, next_addr;
  logic [7:0]  wdat, next_wdat, rdat, next_rdat;
  logic        wr, next_wr, io, next_io, go, next_go, done, next_done;
  logic        auto_w, next_auto_w;
  always_comb begin
    next_st     = st;
    next_addr   = addr;
    next_wdat   = wdat;
    next_rdat   = rdat;
    next_wr     = wr;
    next_io     = io;
    next_go     = go;
    next_done   = 1'b0;
    next_auto_w = auto_w;
    case (st)
      osbb_pkg::OSBB_IDLE: begin
        if (REQ_I && pfail_n) begin
          next_st   = osbb_pkg::OSBB_T1;
          next_addr = REQ_ADDR_I;
          next_wdat = REQ_DATA_I;
          next_wr   = REQ_WRITE_I;
          next_io   = REQ_IO_I;
        end
      end
      osbb_pkg::OSBB_T1: if (fall_en) begin
        next_st = osbb_pkg::OSBB_T2;
        next_go = 1'b1;
      end
      osbb_pkg::OSBB_T2: if (fall_en) begin
        next_st     = osbb_pkg::OSBB_T3;
        next_auto_w = 1'b1;
      end
      osbb_pkg::OSBB_T3, osbb_pkg::OSBB_TW: if (fall_en) begin
        // one forced wait, more while the slot holds wait low
        if (auto_w || !wait_s) begin
          next_st     = osbb_pkg::OSBB_TW;
          next_auto_w = 1'b0;
        end else begin
          next_st   = osbb_pkg::OSBB_T4;
          next_go   = 1'b0;
          next_rdat = bus.bus_data;
        end
      end
      osbb_pkg::OSBB_T4: if (fall_en) begin
        next_st   = osbb_pkg::OSBB_IDLE;
        next_done = 1'b1;
      end
      default: next_st = osbb_pkg::OSBB_IDLE;
    endcase
    if (!pfail_n) begin
      next_st = osbb_pkg::OSBB_IDLE;
      next_go = 1'b0;
    end
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st     <= osbb_pkg::OSBB_IDLE;
      addr   <= 20'h0;
      wdat   <= 8'h0;
      rdat   <= 8'h0;
      wr     <= 1'b0;
      io     <= 1'b0;
      go     <= 1'b0;
      done   <= 1'b0;
      auto_w <= 1'b0;
    end else begin
      st     <= next_st;
      addr   <= next_addr;
      wdat   <= next_wdat;
      rdat   <= next_rdat;
      wr     <= next_wr;
      io     <= next_io;
      go     <= next_go;
      done   <= next_done;
      auto_w <= next_auto_w;
    end
  end

  // ********************************
  // backplane outputs, all from flops
  // ********************************
  logic act, strb_rd, strb_wr, hold_q, irq_s, irq_c, fsize, sel1, sel2;
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      act <= 1'b0; strb_rd <= 1'b1; strb_wr <= 1'b1;
      hold_q <= 1'b0; irq_s <= 1'b0; irq_c <= 1'b0; fsize <= 1'b0;
      sel1 <= 1'b1; sel2 <= 1'b1;
    end else begin
      act     <= (next_st != osbb_pkg::OSBB_IDLE);
      strb_rd <= !((next_st != osbb_pkg::OSBB_IDLE) && !next_wr);
      strb_wr <= !((next_st != osbb_pkg::OSBB_IDLE) && next_wr);
      hold_q  <= hold_s;
      irq_s   <= !sirq_s;
      irq_c   <= !cirq_s;
      fsize   <= msize_s;
      // memory cycles only
      sel1 <= !((next_st != osbb_pkg::OSBB_IDLE) && !next_io &&
                next_addr[19:16] == osbb_pkg::SLOT1_BLOCK);
      sel2 <= !((next_st != osbb_pkg::OSBB_IDLE) && !next_io &&
                next_addr[19:16] == osbb_pkg::SLOT2_BLOCK);
    end
  end
  assign bus.bus_addr       = addr;
  assign bus.data_host      = wdat;
  assign bus.bus_read_n     = strb_rd;
  assign bus.bus_write_n    = strb_wr;
  assign bus.cycle_status_n = !act;
  assign bus.io_not_mem     = io;
  assign bus.data_dir       = wr;
  assign bus.addr_qualify   = go;
  assign bus.hold_ack_sync  = hold_q;
  assign bus.mem_size_flag  = fsize;
  assign bus.slot1_select_n = sel1;
  assign bus.slot2_select_n = sel2;
  assign BUSY_O    = act;
  assign DONE_O    = done;
  assign RD_DATA_O = rdat;
  assign SYS_IRQ_O  = irq_s;
  assign COMM_IRQ_O = irq_c;

  // ********************************
  // frame interrupt timer
  // ********************************
  logic [20:0] fr_cnt, next_fr_cnt;
  logic        fr_irq, next_fr_irq;
  always_comb begin
    next_fr_cnt = fr_cnt + 21'h1;
    next_fr_irq = 1'b1;
    if (fr_cnt == 21'(FRAME_LEN - 1)) begin
      next_fr_cnt = 21'h0;
      next_fr_irq = 1'b0; // one low pulse per frame
    end
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      fr_cnt <= 21'h0;
      fr_irq <= 1'b1;
    end else begin
      fr_cnt <= next_fr_cnt;
      fr_irq <= next_fr_irq;
    end
  end
  assign bus.frame_irq_n = fr_irq;

endmodule

// [hdl/osbb_pkg.sv]
// package: shared constants and types for the option slot backplane bus
// assumes: one 100 MHz clock on both ends, synchronous active-high reset
package osbb_pkg;

  // ********************************
  // bus widths
  // ********************************
  localparam int ADDR_W      = 20;
  localparam int ADDR_LOW_W  = 8;
  localparam int ADDR_MID_W  = 4;
  localparam int ADDR_HIGH_W = 8;
  localparam int DATA_W      = 8;

  // ********************************
  // timing
  // ********************************
  localparam int CLK_NS         = 10;
  localparam int BUS_CLK_NS     = 125;
  // half period of the 8 MHz bus clock, rounded down
  localparam int BUS_HALF_CYC   = (BUS_CLK_NS / 2) / CLK_NS;
  localparam int PFAIL_RISE_US  = 75000;
  localparam int PFAIL_FALL_US  = 500;
  localparam int PFAIL_RISE_CYC = PFAIL_RISE_US * 1000 / CLK_NS;
  localparam int PFAIL_FALL_CYC = PFAIL_FALL_US * 1000 / CLK_NS;
  localparam int WAIT_LEAD_CLKS = 2;
  localparam int FRAME_CYC      = 1666666;

  // ********************************
  // decode
  // ********************************
  localparam logic [3:0] SLOT1_BLOCK = 4'ha;
  localparam logic [3:0] SLOT2_BLOCK = 4'hb;
  localparam logic [7:0] OPT_IO_LO   = 8'h80;
  localparam logic [7:0] OPT_IO_HI   = 8'hff;

  // ********************************
  // bus cycle states, gray along t1..t4
  // ********************************
  typedef enum logic [2:0] {
    OSBB_IDLE = 3'h0,
    OSBB_T1   = 3'h1,
    OSBB_T2   = 3'h3,
    OSBB_T3   = 3'h2,
    OSBB_TW   = 3'h6,
    OSBB_T4   = 3'h7
  } osbb_state_e;

endpackage

// [hdl/osbb_if.sv]
// interface: backplane wires between processor end and option card end
// assumes: open-collector lines resolved here from the enables (low = drive)
`timescale 1ns/10ps
interface osbb_if;
  logic [19:0] bus_addr;
  logic [7:0]  data_host;
  logic [7:0]  data_card;
  logic        data_card_oe_n;
  logic        bus_clock_8m;
  logic        bus_read_n;
  logic        bus_write_n;
  logic        cycle_status_n;
  logic        io_not_mem;
  logic        data_dir;
  logic        addr_qualify;
  logic        slot_wait_oe_n;
  logic        system_irq_oe_n;
  logic        comm_irq_oe_n;
  logic        frame_irq_n;
  logic        hold_ack_sync;
  logic        mem_size_flag;
  logic        slot1_select_n;
  logic        slot2_select_n;
  logic        bus_reset_n;
  logic        power_fail_n;
  // wired-and open-collector levels, and the data lines selected by the card enable
  logic        slot_wait_n;
  logic        system_irq_n;
  logic        comm_shared_irq_n;
  logic [7:0]  bus_data;
  assign slot_wait_n       = slot_wait_oe_n;
  assign system_irq_n      = system_irq_oe_n;
  assign comm_shared_irq_n = comm_irq_oe_n;
  assign bus_data = data_card_oe_n ? data_host : data_card;

  modport host (
    output bus_addr, data_host, bus_clock_8m, bus_read_n, bus_write_n,
    output cycle_status_n, io_not_mem, data_dir, addr_qualify,
    output frame_irq_n, hold_ack_sync, mem_size_flag,
    output slot1_select_n, slot2_select_n, bus_reset_n, power_fail_n,
    input  bus_data, slot_wait_n, system_irq_n, comm_shared_irq_n
  );
  modport card (
    input  bus_addr, bus_data, bus_clock_8m, bus_read_n, bus_write_n,
    input  cycle_status_n, io_not_mem, data_dir, addr_qualify,
    input  frame_irq_n, hold_ack_sync, slot1_select_n, bus_reset_n,
    input  power_fail_n,
    output data_card, data_card_oe_n, slot_wait_oe_n, system_irq_oe_n,
    output comm_irq_oe_n
  );
endinterface

// [hdl/osbb_card.sv]
// option card end: slot-1 memory window and io window 80..ff registers
// assumes: host on the same clock drives the backplane from flops
`timescale 1ns/10ps
module osbb_card (
  // clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RST_I,
  // user side
  input  wire logic [7:0] WAIT_CNT_I,
  input  wire logic       IRQ_REQ_I,
  input  wire logic       COMM_REQ_I,
  input  wire logic [7:0] RD_VALUE_I,
  output logic            WR_STB_O,
  output logic [7:0]      WR_ADDR_O,
  output logic [7:0]      WR_DATA_O,
  // backplane
  osbb_if.card            bus
);

  // ********************************
  // decode and write capture
  // ********************************
  logic       hit;
  logic       go_q, stb, drv, wt, oirq, ocirq;
  logic [7:0] wa, wd, wcnt, next_wcnt, rv;
  // io decode ignores the upper byte
  assign hit = bus.bus_reset_n && (bus.io_not_mem ?
               (bus.bus_addr[7:0] >= osbb_pkg::OPT_IO_LO &&
                bus.bus_addr[7:0] <= osbb_pkg::OPT_IO_HI) :
               !bus.slot1_select_n);
  always_comb begin
    next_wcnt = wcnt;
    if (!bus.addr_qualify)
      next_wcnt = WAIT_CNT_I;
    else if (wcnt != 8'h0)
      next_wcnt = wcnt - 8'h1;
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I || !bus.bus_reset_n) begin
      go_q <= 1'b0; stb <= 1'b0; wa <= 8'h0; wd <= 8'h0;
      drv <= 1'b1; wt <= 1'b1; oirq <= 1'b1; ocirq <= 1'b1;
      wcnt <= 8'h0; rv <= 8'h0;
    end else begin
      go_q <= bus.addr_qualify;
      // capture on qualifier fall
      stb  <= go_q && !bus.addr_qualify && hit && !bus.bus_write_n;
      if (go_q && !bus.addr_qualify) begin
        wa <= bus.bus_addr[7:0];
        wd <= bus.bus_data;
      end
      drv  <= !(hit && !bus.bus_read_n && !bus.data_dir);
      rv   <= RD_VALUE_I;
      wcnt <= next_wcnt;
      wt   <= !(hit && bus.addr_qualify && wcnt != 8'h0);
      oirq  <= !IRQ_REQ_I;  // pull only
      ocirq <= !COMM_REQ_I;
    end
  end
  assign WR_STB_O           = stb;
  assign WR_ADDR_O          = wa;
  assign WR_DATA_O          = wd;
  assign bus.data_card      = rv;
  assign bus.data_card_oe_n = drv;
  assign bus.slot_wait_oe_n = wt;
  assign bus.system_irq_oe_n = oirq;
  assign bus.comm_irq_oe_n  = ocirq;
  // size flag and reserved pins untouched

endmodule

// [bench/osbb_props.sv]
// checker: concurrent properties on the backplane wires between both ends
// assumes: instanced in tb beside the interface, one clock, sync reset
`timescale 1ns/10ps
module osbb_props (
  // clock and reset
  input wire logic        CLK_I,
  input wire logic        RST_I,
  // backplane wires
  input wire logic [19:0] bus_addr,
  input wire logic        bus_read_n,
  input wire logic        bus_write_n,
  input wire logic        io_not_mem,
  input wire logic        data_dir,
  input wire logic        addr_qualify,
  input wire logic        slot_wait_n,
  input wire logic        frame_irq_n,
  input wire logic        slot1_select_n,
  input wire logic        slot2_select_n,
  input wire logic        bus_reset_n,
  input wire logic        data_card_oe_n
);
  // ************************************
  // common clock and reset
  // ************************************
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  // ************************************
  // strobes, direction and decode
  // ************************************
  a_strobe_excl: assert property (bus_read_n || bus_write_n)
    else $error("read and write strobes low together");
  a_dir_match: assert property (
    (!bus_read_n || !bus_write_n) |-> data_dir == !bus_write_n)
    else $error("direction does not follow strobe");
  a_slot1_decode: assert property (
    (!bus_read_n || !bus_write_n) |->
    (!slot1_select_n == (!io_not_mem &&
    bus_addr[19:16] == osbb_pkg::SLOT1_BLOCK)))
    else $error("slot 1 select wrong for address");
  a_slot2_decode: assert property (
    !slot2_select_n |-> !io_not_mem &&
    bus_addr[19:16] == osbb_pkg::SLOT2_BLOCK)
    else $error("slot 2 select outside its block");

  // ************************************
  // qualifier and waits
  // ************************************
  a_go_in_cycle: assert property (
    addr_qualify |-> !bus_read_n || !bus_write_n)
    else $error("qualifier high outside a cycle");
  a_go_min_len: assert property (
    $rose(addr_qualify) |-> addr_qualify [*8])
    else $error("qualifier pulse too short");
  a_go_end_strb: assert property (
    $fell(addr_qualify) |-> (!bus_read_n || !bus_write_n) [*4])
    else $error("strobe ended with qualifier");
  a_wait_holds: assert property (
    (!slot_wait_n) [*4] ##0 addr_qualify |=> addr_qualify)
    else $error("cycle ended while wait held");

  // ************************************
  // frame interrupt, reset and card drive
  // ************************************
  a_frame_pulse: assert property (
    $fell(frame_irq_n) |=> frame_irq_n [*8])
    else $error("frame interrupt not a single pulse");
  a_reset_quiet: assert property (
    !bus_reset_n |-> bus_read_n && bus_write_n && !addr_qualify)
    else $error("bus cycle during bus reset");
  a_card_drive: assert property (
    !data_card_oe_n |-> !bus_read_n || $past(!bus_read_n))
    else $error("card drives data outside a read");
endmodule

// [bench/tb.sv]
// testbench: host and card ends joined by the interface, user sides driven
// assumes: 100 MHz clock, inputs changed on the falling edge, except wait_cnt cleared 1 ns after a rising edge
`timescale 1ns/10ps
module tb;
  // ************************************
  // signals and instances
  // ************************************
  logic clk = 0, rst = 1, req = 0, req_wr = 0, req_io = 0;
  logic [19:0] req_addr = 0;
  logic [7:0] req_data = 0, wait_cnt = 0, rd_value = 8'hc3;
  logic supply_ok = 1, hold = 0, mem_256k = 0, irq_req = 0, comm_req = 0;
  logic busy, done, sys_irq, comm_irq, wr_stb;
  logic [7:0] rd_data, wr_addr, wr_data;
  int fails = 0, check_count = 0, cycles = 0, go_len, bad, s1, s2, stb, n;
  osbb_if bus_if ();
  osbb_host #(.PFAIL_RISE(100), .FRAME_LEN(200)) u_osbb_host (
    .CLK_I(clk), .RST_I(rst), .REQ_I(req), .REQ_WRITE_I(req_wr),
    .REQ_IO_I(req_io), .REQ_ADDR_I(req_addr), .REQ_DATA_I(req_data),
    .BUSY_O(busy), .DONE_O(done), .RD_DATA_O(rd_data),
    .SUPPLY_OK_I(supply_ok), .HOLD_I(hold), .MEM_256K_I(mem_256k),
    .SYS_IRQ_O(sys_irq), .COMM_IRQ_O(comm_irq), .bus(bus_if));
  osbb_card u_osbb_card (
    .CLK_I(clk), .RST_I(rst), .WAIT_CNT_I(wait_cnt), .IRQ_REQ_I(irq_req),
    .COMM_REQ_I(comm_req), .RD_VALUE_I(rd_value), .WR_STB_O(wr_stb),
    .WR_ADDR_O(wr_addr), .WR_DATA_O(wr_data), .bus(bus_if));
  osbb_props u_props (
    .CLK_I(clk), .RST_I(rst), .bus_addr(bus_if.bus_addr),
    .bus_read_n(bus_if.bus_read_n), .bus_write_n(bus_if.bus_write_n),
    .io_not_mem(bus_if.io_not_mem), .data_dir(bus_if.data_dir),
    .addr_qualify(bus_if.addr_qualify), .slot_wait_n(bus_if.slot_wait_n),
    .frame_irq_n(bus_if.frame_irq_n),
    .slot1_select_n(bus_if.slot1_select_n),
    .slot2_select_n(bus_if.slot2_select_n),
    .bus_reset_n(bus_if.bus_reset_n), .data_card_oe_n(bus_if.data_card_oe_n));

  // clock and cycle ceiling
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_sim();
    end
  end

  // ************************************
  // shared tasks
  // ************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  // one bus cycle; watches the wires until done
  task automatic run(input logic wr, input logic io, input logic [19:0] a,
                     input logic [7:0] d, input logic [7:0] wc);
    @(negedge clk);
    req = 1; req_wr = wr; req_io = io; req_addr = a; req_data = d;
    wait_cnt = wc;
    @(negedge clk);
    req = 0;
    go_len = 0; bad = 0; s1 = 0; s2 = 0; stb = 0; n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
      go_len += bus_if.addr_qualify;
      s1 += !bus_if.slot1_select_n;
      s2 += !bus_if.slot2_select_n;
      stb += wr_stb;
      if (!bus_if.bus_read_n || !bus_if.bus_write_n)
        bad += (bus_if.bus_addr !== a || bus_if.io_not_mem !== io ||
                bus_if.data_dir !== wr || bus_if.bus_write_n !== !wr ||
                bus_if.cycle_status_n !== 1'b0);
    end
    check(n < 2000, 1);
    check(bad, 0);
  endtask
  // cycles between two falls of a selected wire
  function automatic logic pick(input int w);
    return w ? bus_if.frame_irq_n : bus_if.bus_clock_8m;
  endfunction
  task automatic period(input int w, output int p);
    logic prev;
    int k;
    for (k = 0; k < 2; k++) begin
      n = 0;
      prev = pick(w);
      @(negedge clk);
      while (!(prev === 1'b1 && pick(w) === 1'b0) && n < 1000) begin
        prev = pick(w);
        @(negedge clk);
        n++;
      end
    end
    p = n + 1;
  endtask

  // ************************************
  // scenarios
  // ************************************
  task automatic t_power();
    n = 0;
    check(bus_if.bus_reset_n, 0);
    while (bus_if.power_fail_n !== 1'b1 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n >= 95 && n <= 115, 1);
    tick(10);
    check(bus_if.bus_reset_n, 1);
    $display("test power done");
  endtask
  task automatic t_cycles();
    run(1, 0, 20'ha0034, 8'h5a, 0);
    check(go_len, 36);
    check({stb[7:0], wr_addr, wr_data}, 24'h01345a);
    check(s1 > 0 && s2 == 0, 1);
    run(0, 0, 20'ha0010, 8'h00, 0);
    check(rd_data, 8'hc3);
    run(0, 0, 20'hb0000, 8'h00, 0);
    check(s2 > 0 && s1 == 0, 1);
    run(1, 1, 20'h0ab80, 8'h11, 0);
    check({stb[7:0], wr_addr, s1[7:0]}, 24'h018000);
    run(1, 1, 20'h0cdff, 8'h22, 0);
    check({stb[7:0], wr_addr, wr_data}, 24'h01ff22);
    run(1, 1, 20'h0ab7f, 8'h33, 0);
    check(stb, 0);
    // wait held 50 clocks from t2: two waits past the automatic one
    run(1, 0, 20'ha0040, 8'h44, 50);
    check(go_len, 60);
    wait_cnt = 0;
    $display("test cycles done");
  endtask
  task automatic t_side();
    int p;
    period(0, p);
    check(p, osbb_pkg::BUS_HALF_CYC * 2);
    period(1, p);
    check(p, 200);
    hold = 1; mem_256k = 1; irq_req = 1; comm_req = 1;
    tick(6);
    check(bus_if.hold_ack_sync, 1);
    check(bus_if.mem_size_flag, 1);
    check({bus_if.system_irq_n, sys_irq}, 2'b01);
    check({bus_if.comm_shared_irq_n, comm_irq}, 2'b01);
    hold = 0; mem_256k = 0; irq_req = 0; comm_req = 0;
    tick(6);
    check({bus_if.hold_ack_sync, bus_if.mem_size_flag}, 0);
    check({bus_if.system_irq_n, sys_irq}, 2'b10);
    check({bus_if.comm_shared_irq_n, comm_irq}, 2'b10);
    $display("test side lines done");
  endtask
  task automatic t_fail();
    supply_ok = 0;
    tick(6);
    check(bus_if.power_fail_n, 0);
    req = 1; req_addr = 20'ha0000;
    tick(1);
    req = 0;
    tick(3);
    check(busy, 0);
    $display("test power fail done");
  endtask

  // ************************************
  // main sequence
  // ************************************
  initial begin
    tick(20);
    rst = 0;
    t_power();
    t_cycles();
    t_side();
    t_fail();
    end_sim();
  end
endmodule
